// ===== inc/adcsq_defines.vh
// constants shared by the converter sequencer design files
`ifndef ADCSQ_DEFINES_VH
`define ADCSQ_DEFINES_VH

// register byte addresses on the wishbone bus
`define ADCSQ_ADDR_CTRL0        4'h0
`define ADCSQ_ADDR_CTRL2        4'h4
`define ADCSQ_ADDR_RES_HIGH     4'h8
`define ADCSQ_ADDR_RES_LOW      4'hC
`define ADCSQ_ADDR_STATUS_W     5'h10

// reset values
`define ADCSQ_CTRL0_RESET       8'h00
`define ADCSQ_CTRL2_RESET       8'h00

// control zero fields
`define ADCSQ_C0_ON             0
`define ADCSQ_C0_GO             1
`define ADCSQ_C0_CHS_LO         2
`define ADCSQ_C0_CHS_HI         5
`define ADCSQ_C0_MASK           8'h3F

// control two fields
`define ADCSQ_C2_CS_LO          0
`define ADCSQ_C2_CS_HI          2
`define ADCSQ_C2_ACQ_LO         3
`define ADCSQ_C2_ACQ_HI         5
`define ADCSQ_C2_FMT            7
`define ADCSQ_C2_MASK           8'hBF

// status register fields
`define ADCSQ_ST_DONE           0
`define ADCSQ_ST_IRQEN          1
`define ADCSQ_ST_GIE            2

// channel limits
`define ADCSQ_CH_LAST           4'hC
`define ADCSQ_CH_LAST_SMALL     4'h9

// clock select codes
`define ADCSQ_CS_RC             3'h7

// timing
`define ADCSQ_BIT_CNT_W         4
`define ADCSQ_BIT_LAST          4'hB
`define ADCSQ_GAP_PERIODS       5'h02
`define ADCSQ_DIV_W             7
`define ADCSQ_RC_DIV            7'h32
`define ADCSQ_TCY_CYCLES        7'h04

// floating input value for unimplemented channels
`define ADCSQ_FLOAT_VALUE       12'h800

`endif

// ===== hw/adcsq_clkgen.v
// conversion bit period enable generator
`timescale 1ns/10ps
module adcsq_clkgen (
    input  wire       clock_in,    // system clock
    input  wire       resetn_in,   // async reset, low
    input  wire       run_in,      // divider runs while high
    input  wire [2:0] sel_in,      // conversion clock select
    output reg        tick_out     // one cycle per bit period
);
`include "adcsq_defines.vh"

    reg  [`ADCSQ_DIV_W-1:0] cnt_reg;    // divider count
    reg  [`ADCSQ_DIV_W-1:0] limit;      // terminal count

    // ----------------------------------------------------------
    // division table
    // ----------------------------------------------------------
    // codes 0..7 give fosc/2,8,32,2,4,16,64,rc; rc is modelled by a fixed
    // slow division since the internal oscillator is not in this clock
    always @* begin
        case (sel_in)
            3'h0:    limit = 7'h01;
            3'h1:    limit = 7'h07;
            3'h2:    limit = 7'h1F;
            3'h4:    limit = 7'h03;
            3'h5:    limit = 7'h0F;
            3'h6:    limit = 7'h3F;
            `ADCSQ_CS_RC: limit = `ADCSQ_RC_DIV;
            default: limit = 7'h01;
        endcase
    end

    // free divider, held at zero while run is low, restarts when run rises
    always @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cnt_reg  <= 7'h00;
            tick_out <= 1'b0;
        end else if (!run_in) begin
            cnt_reg  <= 7'h00;
            tick_out <= 1'b0;
        end else if (cnt_reg >= limit) begin
            cnt_reg  <= 7'h00;
            tick_out <= 1'b1;
        end else begin
            cnt_reg  <= cnt_reg + 7'h01;
            tick_out <= 1'b0;
        end
    end
endmodule

// ===== hw/adcsq_sar.v
// successive approximation register, one bit per tick
`timescale 1ns/10ps
module adcsq_sar (
    input  wire        clock_in,    // system clock
    input  wire        resetn_in,   // async reset, low
    input  wire        load_in,     // start a new approximation
    input  wire        tick_in,     // bit period enable
    input  wire        cmp_in,      // comparator: input above trial
    output reg  [11:0] trial_out,   // current trial code
    output reg         last_out     // final bit decided on the previous tick
);
`include "adcsq_defines.vh"

    reg  [`ADCSQ_BIT_CNT_W-1:0] idx_reg;  // bits decided so far
    reg  [11:0]                 mask_reg; // bit under trial

    // approximation walks from msb down to lsb
    always @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            trial_out <= 12'h000;
            mask_reg  <= 12'h800;
            idx_reg   <= 4'h0;
            last_out  <= 1'b0;
        end else if (load_in) begin
            trial_out <= 12'h800;
            mask_reg  <= 12'h800;
            idx_reg   <= 4'h0;
            last_out  <= 1'b0;
        end else if (tick_in) begin
            // keep or drop the trial bit, then set the next one
            trial_out <= (cmp_in ? trial_out : (trial_out & ~mask_reg)) | (mask_reg >> 1);
            mask_reg  <= mask_reg >> 1;
            idx_reg   <= idx_reg + 4'h1;
            last_out  <= (idx_reg == `ADCSQ_BIT_LAST);
        end else begin
            last_out  <= 1'b0;
        end
    end
endmodule

// ===== hw/adcsq_top.v
// converter sequencer: registers, acquisition, conversion and result
//
// Chosen here: the address map and the Wishbone register port.
`timescale 1ns/10ps
`include "adcsq_defines.vh"
// Function
// (R1) channel code 0..12 valid; above picks none
// (R2) unimplemented channel still converts, floating value
// (R3) 12-bit result in high/low byte pair
// (R4) start flag set starts; clears at completion
// (R5) software powers and configures before starting
// (R6) format bit selects right or left justify
// (R7) acquisition code maps to 20..0 periods
// (R8) acquisition interval counted before conversion
// (R9) clock select picks rc or fosc division
// (R10) rc clock adds one instruction cycle delay
// (R11) result untouched by bus reset
// (R12) wait two bit periods before next acquisition
// (R13) done flag set at completion, software clears
// (R14) software allows minimum sampling after channel change
// (R15) software adjusts clock select in power modes
// (R16) clock source held during conversion; here a ctrl2 write changes clk_sel at once, even mid-conversion
// (R17) rc clock recommended below 1 mhz
// (R18) rc clock required for sleep conversions
// (R19) zero acquisition delays one instruction cycle
// (R20) idle-on-sleep cleared before sleep conversion
// (R21) compare trigger starts when on, else ignored
// (R22) result, flag clear and done in one cycle
module adcsq_top (
    input  wire        clock_in,      // system clock, 50 mhz
    input  wire        resetn_in,     // async reset, low
    input  wire        por_in,        // power-on or brown-out reset pulse
    input  wire        large_pkg_in,  // high on 13-input packages
    input  wire [31:0] wb_adr_in,     // wishbone address
    input  wire [31:0] wb_dat_in,     // wishbone write data
    input  wire [3:0]  wb_sel_in,     // wishbone byte selects
    input  wire        wb_we_in,      // wishbone write enable
    input  wire        wb_cyc_in,     // wishbone cycle
    input  wire        wb_stb_in,     // wishbone strobe
    output reg  [31:0] wb_dat_out,    // wishbone read data
    output reg         wb_ack_out,    // wishbone acknowledge
    input  wire        trig_in,       // compare unit special event pulse
    input  wire        trig_mode_in,  // compare unit in trigger mode
    input  wire        cmp_in,        // analog comparator result
    output reg  [3:0]  mux_sel_out,   // analog input mux select
    output reg         mux_valid_out, // selected input exists
    output reg         sample_out,    // hold capacitor connected
    output reg  [11:0] dac_out,       // trial code to the dac
    output reg         irq_out        // conversion done interrupt
);

    // ----------------------------------------------------------
    // sequencer states
    // ----------------------------------------------------------
    localparam ST_IDLE  = 3'h0;  // waiting for start
    localparam ST_DELAY = 3'h1;  // one instruction cycle delay
    localparam ST_ACQ   = 3'h2;  // programmed acquisition
    localparam ST_CONV  = 3'h3;  // approximating
    localparam ST_GAP   = 3'h4;  // discharge before next acquisition

    // ----------------------------------------------------------
    // registers and state
    // ----------------------------------------------------------
    reg  [7:0]  ctrl0_reg;       // channel, start flag, power
    reg  [7:0]  ctrl2_reg;       // format, acquisition, clock select
    reg  [11:0] result_reg;      // last conversion result
    reg         done_reg;        // conversion done flag
    reg         irqen_reg;       // conversion irq enable
    reg         gie_reg;         // global irq enable
    reg  [2:0]  state_reg;       // sequencer state
    reg  [4:0]  acq_cnt_reg;     // periods left in acquisition or gap
    reg  [6:0]  dly_cnt_reg;     // instruction cycle delay count
    reg         float_reg;       // conversion on missing channel
    reg  [7:0]  rd_data;         // read mux
    reg  [4:0]  acq_periods;     // decoded acquisition length

    wire        bus_req;         // valid access this cycle
    wire        bus_wr;          // write strobe, lane 0
    wire [4:0]  byte_adr;        // low address bits
    wire        conv_on;         // converter powered
    wire        go_flag;         // start flag
    wire [3:0]  chan;            // channel select
    wire        chan_ok;         // channel is implemented
    wire [2:0]  clk_sel;         // conversion clock select
    wire [2:0]  acq_sel;         // acquisition select
    wire        tick;            // bit period enable
    wire        sar_last;        // approximation finished
    wire [11:0] trial;           // sar trial code
    wire        run_div;         // divider enabled
    wire        sw_go;           // software writes start flag high
    wire        hw_go;           // trigger start
    wire [15:0] res_pair;        // justified result pair
    wire        conv_end;        // conversion completes this cycle

    assign bus_req  = wb_cyc_in & wb_stb_in & ~wb_ack_out;
    assign bus_wr   = bus_req & wb_we_in & wb_sel_in[0];
    assign byte_adr = wb_adr_in[4:0];
    assign conv_on  = ctrl0_reg[`ADCSQ_C0_ON];
    assign go_flag  = ctrl0_reg[`ADCSQ_C0_GO];
    assign chan     = ctrl0_reg[`ADCSQ_C0_CHS_HI:`ADCSQ_C0_CHS_LO];
    assign clk_sel  = ctrl2_reg[`ADCSQ_C2_CS_HI:`ADCSQ_C2_CS_LO];
    assign acq_sel  = ctrl2_reg[`ADCSQ_C2_ACQ_HI:`ADCSQ_C2_ACQ_LO];
    // small packages stop at input 9, large at 12
    assign chan_ok  = large_pkg_in ? (chan <= `ADCSQ_CH_LAST) : (chan <= `ADCSQ_CH_LAST_SMALL); // R1
    assign sw_go    = bus_wr && (byte_adr == {1'b0, `ADCSQ_ADDR_CTRL0}) && wb_dat_in[`ADCSQ_C0_GO]
                      && wb_dat_in[`ADCSQ_C0_ON];
    assign hw_go    = trig_in & trig_mode_in & conv_on; // R21
    assign run_div  = (state_reg == ST_ACQ) || (state_reg == ST_CONV) || (state_reg == ST_GAP);
    assign conv_end = (state_reg == ST_CONV) && sar_last;

    // ----------------------------------------------------------
    // result justification
    // ----------------------------------------------------------
    // right justify pads zeros above, left justify pads below
    assign res_pair = ctrl2_reg[`ADCSQ_C2_FMT] ? {4'h0, result_reg} : {result_reg, 4'h0}; // R6 R3

    // acquisition code to bit periods
    always @* begin
        case (acq_sel) // R7
            3'h7:    acq_periods = 5'h14;
            3'h6:    acq_periods = 5'h10;
            3'h5:    acq_periods = 5'h0C;
            3'h4:    acq_periods = 5'h08;
            3'h3:    acq_periods = 5'h06;
            3'h2:    acq_periods = 5'h04;
            3'h1:    acq_periods = 5'h02;
            default: acq_periods = 5'h00;
        endcase
    end

    // ----------------------------------------------------------
    // bit clock and approximation engines
    // ----------------------------------------------------------
    adcsq_clkgen u_clkgen (
        .clock_in  (clock_in),
        .resetn_in (resetn_in),
        .run_in    (run_div),
        .sel_in    (clk_sel), // R9
        .tick_out  (tick)
    );

    adcsq_sar u_sar (
        .clock_in  (clock_in),
        .resetn_in (resetn_in),
        .load_in   (state_reg != ST_CONV),
        .tick_in   (tick & (state_reg == ST_CONV)),
        .cmp_in    (cmp_in),
        .trial_out (trial),
        .last_out  (sar_last)
    );

    // ----------------------------------------------------------
    // control registers and sequencer
    // ----------------------------------------------------------
    // start flag is owned here: software or the compare trigger sets it, hardware clears it
    always @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ctrl0_reg   <= `ADCSQ_CTRL0_RESET;
            ctrl2_reg   <= `ADCSQ_CTRL2_RESET;
            done_reg    <= 1'b0;
            irqen_reg   <= 1'b0;
            gie_reg     <= 1'b0;
            state_reg   <= ST_IDLE;
            acq_cnt_reg <= 5'h00;
            dly_cnt_reg <= 7'h00;
            float_reg   <= 1'b0;
        end else begin
            // plain register writes
            if (bus_wr && byte_adr == {1'b0, `ADCSQ_ADDR_CTRL0}) begin
                ctrl0_reg[`ADCSQ_C0_CHS_HI:`ADCSQ_C0_CHS_LO] <= wb_dat_in[`ADCSQ_C0_CHS_HI:`ADCSQ_C0_CHS_LO];
                ctrl0_reg[`ADCSQ_C0_ON] <= wb_dat_in[`ADCSQ_C0_ON];
            end
            if (bus_wr && byte_adr == {1'b0, `ADCSQ_ADDR_CTRL2}) begin
                ctrl2_reg <= wb_dat_in[7:0] & `ADCSQ_C2_MASK;
            end
            if (bus_wr && byte_adr == `ADCSQ_ADDR_STATUS_W) begin
                irqen_reg <= wb_dat_in[`ADCSQ_ST_IRQEN];
                gie_reg   <= wb_dat_in[`ADCSQ_ST_GIE];
                // clearing done loses to a completion in the same cycle
                if (!wb_dat_in[`ADCSQ_ST_DONE] && !conv_end) begin
                    done_reg <= 1'b0; // R13
                end
            end
            case (state_reg)
                ST_IDLE: begin
                    // a start with the converter off is not taken
                    if ((sw_go || hw_go) && !go_flag) begin // R4 R21
                        ctrl0_reg[`ADCSQ_C0_GO] <= 1'b1;
                        float_reg   <= ~chan_ok; // R2
                        acq_cnt_reg <= acq_periods;
                        dly_cnt_reg <= `ADCSQ_TCY_CYCLES;
                        // rc clock or zero acquisition first lets a sleep execute
                        if (clk_sel == `ADCSQ_CS_RC || acq_periods == 5'h00) begin // R10 R19
                            state_reg <= ST_DELAY;
                        end else begin
                            state_reg <= ST_ACQ; // R8
                        end
                    end
                end
                ST_DELAY: begin
                    // one instruction cycle of four system clocks
                    if (dly_cnt_reg <= 7'h01) begin
                        state_reg <= (acq_cnt_reg == 5'h00) ? ST_CONV : ST_ACQ;
                    end else begin
                        dly_cnt_reg <= dly_cnt_reg - 7'h01;
                    end
                end
                ST_ACQ: begin
                    if (acq_cnt_reg == 5'h00) begin
                        state_reg <= ST_CONV;
                    end else if (tick) begin
                        acq_cnt_reg <= acq_cnt_reg - 5'h01; // R8
                    end
                end
                ST_CONV: begin
                    if (!conv_on) begin
                        // powering down aborts without a result
                        ctrl0_reg[`ADCSQ_C0_GO] <= 1'b0;
                        state_reg <= ST_IDLE;
                    end else if (sar_last) begin
                        // flag drop and done rise land with the result
                        ctrl0_reg[`ADCSQ_C0_GO] <= 1'b0; // R22 R4
                        done_reg    <= 1'b1; // R13
                        acq_cnt_reg <= `ADCSQ_GAP_PERIODS;
                        state_reg   <= ST_GAP;
                    end
                end
                ST_GAP: begin
                    // sample switch stays open for two periods after the end
                    if (acq_cnt_reg == 5'h00) begin
                        state_reg <= ST_IDLE; // R12
                    end else if (tick) begin
                        acq_cnt_reg <= acq_cnt_reg - 5'h01;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------
    // result register
    // ----------------------------------------------------------
    // no bus reset here: only a power-on or brown-out pulse disturbs it,
    // and then it loads the fixed floating value 12'h800
    always @(posedge clock_in) begin
        if (por_in) begin
            result_reg <= `ADCSQ_FLOAT_VALUE; // R11
        end else if (conv_end && conv_on) begin
            result_reg <= float_reg ? `ADCSQ_FLOAT_VALUE : trial; // R22 R2 R3
        end
    end

    // ----------------------------------------------------------
    // wishbone read mux
    // ----------------------------------------------------------
    always @* begin
        case (byte_adr)
            {1'b0, `ADCSQ_ADDR_CTRL0}:    rd_data = ctrl0_reg & `ADCSQ_C0_MASK;
            {1'b0, `ADCSQ_ADDR_CTRL2}:    rd_data = ctrl2_reg;
            {1'b0, `ADCSQ_ADDR_RES_HIGH}: rd_data = res_pair[15:8];
            {1'b0, `ADCSQ_ADDR_RES_LOW}:  rd_data = res_pair[7:0];
            `ADCSQ_ADDR_STATUS_W:         rd_data = {5'h00, gie_reg, irqen_reg, done_reg};
            default:                      rd_data = 8'h00;
        endcase
    end

    // single-wait-state slave; unmapped reads return zero
    always @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h0000_0000;
        end else begin
            wb_ack_out <= bus_req;
            wb_dat_out <= bus_req ? {24'h00_0000, rd_data} : 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------
    // analog side and interrupt outputs
    // ----------------------------------------------------------
    always @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mux_sel_out   <= 4'h0;
            mux_valid_out <= 1'b0;
            sample_out    <= 1'b0;
            dac_out       <= 12'h000;
            irq_out       <= 1'b0;
        end else begin
            mux_sel_out   <= chan;
            mux_valid_out <= chan_ok; // R1
            // hold capacitor tracks while powered, except while converting or discharging
            sample_out    <= conv_on && (state_reg != ST_CONV) && (state_reg != ST_GAP);
            dac_out       <= trial;
            irq_out       <= done_reg & irqen_reg & gie_reg; // R13
        end
    end
endmodule

// ===== bench/adcsq_checker.sv
// port-level assertions for the converter sequencer
`timescale 1ns/10ps
module adcsq_checker (
    input wire logic        clock_in,      // system clock
    input wire logic        resetn_in,     // async reset, low
    input wire logic        large_pkg_in,  // 13-input package
    input wire logic        wb_cyc_in,     // bus cycle
    input wire logic        wb_stb_in,     // bus strobe
    input wire logic        wb_we_in,      // bus write
    input wire logic [31:0] wb_dat_out,    // bus read data
    input wire logic        wb_ack_out,    // bus acknowledge
    input wire logic [3:0]  mux_sel_out,   // channel select
    input wire logic        mux_valid_out, // channel exists
    input wire logic        sample_out,    // hold cap connected
    input wire logic        irq_out        // done interrupt
);
    // write requests seen one and two edges back; a clear may land a cycle late
    logic wr_d1_reg; // one edge back
    logic wr_d2_reg; // two edges back
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wr_d1_reg <= 1'b0;
            wr_d2_reg <= 1'b0;
        end else begin
            wr_d1_reg <= wb_cyc_in & wb_stb_in & wb_we_in;
            wr_d2_reg <= wr_d1_reg;
        end
    end
    // --------------------------------
    // assertions
    // --------------------------------
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!resetn_in);
    AST_ACK_LATENCY: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
        else $error("ack missing one cycle after request");
    AST_ACK_PULSE: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("ack longer than one cycle");
    AST_ACK_CAUSE: assert property ($rose(wb_ack_out) |-> $past(wb_cyc_in) && $past(wb_stb_in))
        else $error("ack without request");
    AST_DATA_IDLE: assert property (!wb_ack_out |-> wb_dat_out == 32'h0000_0000)
        else $error("read data outside ack");
    AST_VALID_RANGE: assert property (mux_valid_out |-> mux_sel_out <= 4'hC)
        else $error("channel above twelve marked valid");
    AST_VALID_SMALL: assert property (mux_valid_out && !large_pkg_in && !$past(large_pkg_in)
        && !$past(large_pkg_in, 2) |-> mux_sel_out <= 4'h9) else $error("small package channel valid");
    AST_IRQ_CLEAR: assert property ($fell(irq_out) |-> wr_d1_reg || wr_d2_reg)
        else $error("interrupt dropped without a write");
    AST_IRQ_IN_GAP: assert property ($rose(irq_out) |-> !sample_out [*2])
        else $error("sampling resumed right after done");
    AST_RESET_QUIET: assert property (disable iff (1'b0) !resetn_in |->
        !wb_ack_out && !irq_out && !sample_out && !mux_valid_out) else $error("outputs active in reset");
    cover property ($rose(irq_out));
    cover property ($fell(sample_out));
    cover property (wb_ack_out && wb_we_in);
endmodule
bind adcsq_top adcsq_checker chk_u (.*);

// ===== bench/adcsq_top_tb_top.sv
// self-checking bench for the converter sequencer
`timescale 1ns/10ps
`include "adcsq_defines.vh"
module adcsq_top_tb_top;
    logic        clock_in, resetn_in, por_in, large_pkg_in; // clock, resets, package
    logic        wb_we_in, wb_cyc_in, wb_stb_in, trig_in;   // bus controls, trigger
    logic        trig_mode_in, cmp_in;                      // trigger mode, comparator
    logic [31:0] wb_adr_in, wb_dat_in;                      // bus address, data
    logic [3:0]  wb_sel_in; // byte lanes
    wire  [31:0] wb_dat_out; // read data
    wire         wb_ack_out, mux_valid_out, sample_out, irq_out; // status
    wire  [3:0]  mux_sel_out; // channel
    wire  [11:0] dac_out; // trial code
    int          err_count, checked, t1, t2, r1, r2, n;     // counters, timings
    logic [7:0]  d; // last read byte
    int          per[8] = '{0, 2, 4, 6, 8, 12, 16, 20};     // acquisition periods
    int          tk[8] = '{2, 8, 32, 2, 4, 16, 64, 51};     // clocks per bit period
    localparam logic [4:0] a_c0 = {1'b0, `ADCSQ_ADDR_CTRL0};
    localparam logic [4:0] a_c2 = {1'b0, `ADCSQ_ADDR_CTRL2};
    localparam logic [4:0] a_hi = {1'b0, `ADCSQ_ADDR_RES_HIGH};
    localparam logic [4:0] a_lo = {1'b0, `ADCSQ_ADDR_RES_LOW};
    localparam logic [4:0] a_st = `ADCSQ_ADDR_STATUS_W;
    adcsq_top dut_u (.*);
    always #10 clock_in = ~clock_in; // 50 mhz
    // --------------------------------
    // shared tasks
    // --------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one classic cycle; data taken and request dropped at the edge that sees ack
    task bus(input logic we, input logic [4:0] adr, input logic [7:0] wd);
        n = 0;
        @(posedge clock_in);
        {wb_cyc_in, wb_stb_in, wb_we_in} <= {2'b11, we};
        wb_adr_in <= {27'h000_0000, adr};
        wb_dat_in <= {24'h00_0000, wd};
        do begin
            @(posedge clock_in);
            n++;
        end while (wb_ack_out !== 1'b1 && n < 100);
        if (n >= 100) err_count++;
        d = wb_dat_out[7:0];
        {wb_cyc_in, wb_stb_in, wb_we_in} <= 3'b000;
    endtask
    task rd(input logic [4:0] adr, input logic [7:0] exp);
        bus(1'b0, adr, 8'h00);
        chk(d, exp);
    endtask
    task res(input logic [7:0] hi, input logic [7:0] lo);
        rd(a_hi, hi);
        rd(a_lo, lo);
    endtask
    // set up and start; t1 to sample stop, t2 to done
    task conv(input logic [7:0] c2, input logic [3:0] ch, input logic cm);
        cmp_in <= cm;
        bus(1'b1, a_c2, c2);
        bus(1'b1, a_st, 8'h06);
        bus(1'b1, a_c0, {2'b00, ch, 2'b01});
        bus(1'b1, a_c0, {2'b00, ch, 2'b11});
        t1 = 0;
        t2 = 0;
        while (sample_out !== 1'b0 && t1 < 3000) begin @(negedge clock_in); t1++; end
        while (irq_out !== 1'b1 && t2 < 3000) begin @(negedge clock_in); t2++; end
        rd(a_c0, {2'b00, ch, 2'b01});
        chk(dac_out, 12'h800);
    endtask
    task waitc(input int k);
        repeat (k) @(posedge clock_in);
    endtask
    task pulse;
        @(posedge clock_in);
        trig_in <= 1'b1;
        @(posedge clock_in);
        trig_in <= 1'b0;
    endtask
    // --------------------------------
    // scenarios
    // --------------------------------
    task t_regs;
        rd(a_c0, 8'h00);
        rd(a_c2, 8'h00);
        bus(1'b1, a_c2, 8'hFF);
        rd(a_c2, 8'hBF);
        bus(1'b1, a_c0, 8'hC1);
        rd(a_c0, 8'h01);
        bus(1'b1, 5'h14, 8'hFF); // unmapped: dropped
        rd(5'h14, 8'h00);
        rd(a_c0, 8'h01);
    endtask
    task t_chan;
        logic [3:0] chs[4] = '{4'h9, 4'hA, 4'hC, 4'hD}; // boundary codes
        for (int p = 0; p < 2; p++) foreach (chs[i]) begin
            large_pkg_in <= p[0];
            bus(1'b1, a_c0, {2'b00, chs[i], 2'b01});
            waitc(2);
            chk(mux_sel_out, chs[i]);
            chk(mux_valid_out, chs[i] <= (p ? 4'hC : 4'h9));
        end
    endtask
    task t_acq;
        for (int i = 1; i < 9; i++) begin
            conv({2'b10, i[2:0], 3'b000}, 4'h5, 1'b1);
            res(8'h0F, 8'hFF);
            if (i == 1) r1 = t1;
            else if (i < 8) chk(t1 - r1, (per[i] - 2) * 2);
            else chk(r1 - t1, 2);
        end
    endtask
    task t_clk;
        for (int s = 0; s < 8; s++) begin
            conv({5'b00001, s[2:0]}, 4'h3, 1'b0);
            res(8'h00, 8'h00);
            if (s == 0) {r1, r2} = {t1, t2};
            else chk(t2 - r2, 12 * (tk[s] - 2));
            if (s == 7) chk(t1 - r1, 4 + 2 * (tk[7] - 2));
            waitc(150);
        end
    endtask
    task t_misc;
        conv(8'h08, 4'hD, 1'b1);
        res(8'h80, 8'h00);
        waitc(10);
        conv(8'h08, 4'h5, 1'b1);
        res(8'hFF, 8'hF0);
        waitc(10);
    endtask
    task t_gap;
        conv(8'h0E, 4'h5, 1'b1);
        bus(1'b1, a_c0, 8'h17); // start inside the gap is dropped
        rd(a_c0, 8'h15);
        waitc(150);
        conv(8'h0E, 4'h5, 1'b1);
        chk(t2 < 3000, 1'b1);
        waitc(150);
    endtask
    task t_trig;
        bus(1'b1, a_st, 8'h06);
        trig_mode_in <= 1'b1;
        pulse();
        rd(a_c0, 8'h17);
        n = 0;
        while (irq_out !== 1'b1 && n < 3000) begin @(negedge clock_in); n++; end
        chk(n < 3000, 1'b1);
        waitc(150);
        bus(1'b1, a_c0, 8'h14);
        pulse();
        rd(a_c0, 8'h14);
    endtask
    task t_reset;
        conv(8'h08, 4'h5, 1'b1);
        @(posedge clock_in);
        resetn_in <= 1'b0;
        waitc(3);
        resetn_in <= 1'b1;
        res(8'hFF, 8'hF0);
        rd(a_c0, 8'h00);
        por_in <= 1'b1;
        @(posedge clock_in);
        por_in <= 1'b0;
        res(8'h80, 8'h00);
    endtask
    task finish_test;
        $display("comparisons %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        {clock_in, resetn_in, por_in, large_pkg_in, trig_in, trig_mode_in, cmp_in} = 7'b000_0000;
        {wb_we_in, wb_cyc_in, wb_stb_in, wb_sel_in} = 7'b000_0001;
        {wb_adr_in, wb_dat_in} = 64'h0000_0000_0000_0000;
        waitc(20);
        resetn_in <= 1'b1;
        t_regs();
        t_chan();
        t_acq();
        t_clk();
        t_misc();
        t_gap();
        t_trig();
        t_reset();
        finish_test();
    end
    // watchdog, far past the expected run
    initial begin
        #(20 * 90000);
        err_count++;
        finish_test();
    end
endmodule
